// >>> pkg/i2cdw_defines.vh
`ifndef I2CDW_DEFINES_VH
`define I2CDW_DEFINES_VH

// ----------------------------------------
// Slave address
// ----------------------------------------
`define I2CDW_ADDR_HIGH6 6'h1E
`define I2CDW_ADDR_SEL_POS 1
`define I2CDW_RW_POS 0

// ----------------------------------------
// Control byte fields
// ----------------------------------------
`define I2CDW_CTRL_CONT_POS 7
`define I2CDW_CTRL_DC_POS 6

// ----------------------------------------
// Reset values, widths and bit counter values
// ----------------------------------------
`define I2CDW_COL_RESET 7'h00
`define I2CDW_COL_WIDTH 7
`define I2CDW_BIT_LAST 4'h7
`define I2CDW_BIT_ACK 4'h8

`endif

// >>> verilog/i2cdw_sync.v
`timescale 1ns/1ps
`default_nettype none

// Two-stage synchroniser; first stage feeds only the second
module i2cdw_sync #(
  parameter RESET_VALUE = 1'b1
) (
  input wire clk,
  input wire rst_n,
  input wire d,
  output reg q
);
  reg meta;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= RESET_VALUE;
      q <= RESET_VALUE;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

`default_nettype wire

// >>> verilog/i2cdw_edge.v
`timescale 1ns/1ps
`default_nettype none

// Edge finder on an already synchronised level
module i2cdw_edge #(
  parameter RESET_VALUE = 1'b1
) (
  input wire clk,
  input wire rst_n,
  input wire level,
  output wire rise,
  output wire fall
);
  reg prev;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev <= RESET_VALUE;
    end else begin
      prev <= level;
    end
  end

  assign rise = level & ~prev;
  assign fall = ~level & prev;
endmodule

`default_nettype wire

// >>> verilog/i2cdw_top.v
// What this block does
// - Answer only address 011110x where x equals the address-select strap.
// - Address bit zero picks read (1) or write (0) mode.
// - SDA falling while SCL high starts a new address phase.
// - SDA rising while SCL high ends the write transfer.
// - Acknowledge every accepted byte by holding SDA low in ninth clock high.
// - Control byte holds continuation flag, selector flag, six zeros.
// - Continuation flag zero makes every later byte payload.
// - Selector zero sends next byte to commands; one sends to display RAM.
// - Each display RAM write advances column pointer by one.
// - One data bit sampled per SCL period; eight bits then ack.
// - SDA output optional; master ignores missing acknowledges.
// - Chip init pin low resets all interface state.
// - Chip init pin clears partly received shift register bits.
//
`timescale 1ns/1ps
`default_nettype none
`include "i2cdw_defines.vh"

module i2cdw_top #(
  parameter COL_WIDTH = `I2CDW_COL_WIDTH
) (
  input wire clk,
  input wire rst_n,
  input wire chip_init_pin_n,
  input wire scl,
  input wire sda_in,
  input wire address_select_bit,
  output reg sda_out,
  output reg sda_oe,
  output reg read_mode,
  output reg busy,
  output reg cmd_valid,
  output reg [7:0] cmd_byte,
  output reg ram_valid,
  output reg [7:0] ram_byte,
  output reg [COL_WIDTH-1:0] ram_col
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_CTRL = 3'h2;
  localparam ST_DATA = 3'h3;
  localparam ST_READ = 3'h4;

  // ----------------------------------------
  // Input crossing
  // ----------------------------------------
  wire scl_s;
  wire sda_s;
  wire init_s;
  wire scl_rise;
  wire scl_fall;
  wire sda_rise;
  wire sda_fall;
  wire clear_all;

  i2cdw_sync #(.RESET_VALUE(1'b1)) u_sync_scl (
    .clk(clk), .rst_n(rst_n), .d(scl), .q(scl_s)
  );
  i2cdw_sync #(.RESET_VALUE(1'b1)) u_sync_sda (
    .clk(clk), .rst_n(rst_n), .d(sda_in), .q(sda_s)
  );
  i2cdw_sync #(.RESET_VALUE(1'b0)) u_sync_init (
    .clk(clk), .rst_n(rst_n), .d(chip_init_pin_n), .q(init_s)
  );

  wire strap_s;

  // Strap is a pin as well, so it gets the same two-stage crossing
  i2cdw_sync #(.RESET_VALUE(1'b0)) u_sync_strap (
    .clk(clk), .rst_n(rst_n), .d(address_select_bit), .q(strap_s)
  );

  i2cdw_edge #(.RESET_VALUE(1'b1)) u_edge_scl (
    .clk(clk), .rst_n(rst_n), .level(scl_s), .rise(scl_rise), .fall(scl_fall)
  );
  i2cdw_edge #(.RESET_VALUE(1'b1)) u_edge_sda (
    .clk(clk), .rst_n(rst_n), .level(sda_s), .rise(sda_rise), .fall(sda_fall)
  );

  // Start/stop only count while SCL stays high
  wire start_seen = sda_fall & scl_s & ~scl_fall;
  wire stop_seen = sda_rise & scl_s & ~scl_fall;
  wire bus_event = start_seen | stop_seen;
  assign clear_all = ~init_s;

  // ----------------------------------------
  // Byte engine state
  // ----------------------------------------
  reg [2:0] state;
  reg [3:0] bit_cnt;
  reg [7:0] shift;
  reg ack_pend;
  reg payload_only;
  reg sel_ram;
  reg have_sel;
  reg [2:0] next_state;
  reg [3:0] next_bit_cnt;
  reg [7:0] next_shift;
  reg next_ack_pend;
  reg next_payload_only;
  reg next_sel_ram;
  reg next_have_sel;
  reg next_read_mode;
  reg next_busy;

  wire [7:0] full_byte = {shift[6:0], sda_s};
  wire addr_match = (full_byte[7:2] == `I2CDW_ADDR_HIGH6) &&
    (full_byte[`I2CDW_ADDR_SEL_POS] == strap_s);
  // Read frames are acknowledged but not served, so they count as idle here
  wire in_frame = (state != ST_IDLE) && (state != ST_READ);
  wire bit_take = in_frame && scl_rise && (bit_cnt <= `I2CDW_BIT_LAST);
  wire byte_done = bit_take && (bit_cnt == `I2CDW_BIT_LAST);
  wire ack_on = in_frame && scl_fall && ack_pend && !sda_oe;
  wire ack_off = in_frame && scl_fall && sda_oe;
  // A start or stop in the same cycle wins over a finished byte
  wire payload_done = byte_done && (state == ST_DATA) && !bus_event;
  wire [COL_WIDTH-1:0] col_step = {{(COL_WIDTH-1){1'b0}}, 1'b1};

  // ----------------------------------------
  // Frame sequencer: next values
  // ----------------------------------------
  always @* begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_shift = shift;
    next_ack_pend = ack_pend;
    next_payload_only = payload_only;
    next_sel_ram = sel_ram;
    next_have_sel = have_sel;
    next_read_mode = read_mode;
    next_busy = busy;
    if (start_seen) begin
      next_state = ST_ADDR;
      next_bit_cnt = 4'h0;
      next_shift = 8'h00;
      next_ack_pend = 1'b0;
      next_payload_only = 1'b0;
      next_have_sel = 1'b0;
      next_read_mode = 1'b0;
      next_busy = 1'b1;
    end else if (stop_seen) begin
      next_state = ST_IDLE;
      next_bit_cnt = 4'h0;
      next_ack_pend = 1'b0;
      next_busy = 1'b0;
    end else if (bit_take) begin
      // SDA is steady while SCL is high, so one sample per period is enough
      next_shift = full_byte;
      if (bit_cnt == `I2CDW_BIT_LAST) begin
        next_bit_cnt = `I2CDW_BIT_ACK;
        case (state)
          ST_ADDR: begin
            if (addr_match) begin
              next_ack_pend = 1'b1;
              next_read_mode = full_byte[`I2CDW_RW_POS];
            end else begin
              next_state = ST_IDLE;
              next_busy = 1'b0;
            end
          end
          ST_CTRL: begin
            next_ack_pend = 1'b1;
            next_payload_only = ~full_byte[`I2CDW_CTRL_CONT_POS];
            next_sel_ram = full_byte[`I2CDW_CTRL_DC_POS];
            next_have_sel = 1'b1;
          end
          default: begin
            next_ack_pend = 1'b1;
          end
        endcase
      end else begin
        next_bit_cnt = bit_cnt + 4'h1;
      end
    end else if (ack_off) begin
      next_ack_pend = 1'b0;
      next_bit_cnt = 4'h0;
      case (state)
        ST_ADDR: begin
          // Read data path is outside this block: idle until the next start or stop
          next_state = read_mode ? ST_READ : ST_CTRL;
        end
        ST_CTRL: begin
          next_state = ST_DATA;
        end
        default: begin
          // Continuation set: one payload byte, then a control byte again
          if (!payload_only && have_sel) begin
            next_state = ST_CTRL;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Frame sequencer: registers
  // ----------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      ack_pend <= 1'b0;
      payload_only <= 1'b0;
      sel_ram <= 1'b0;
      have_sel <= 1'b0;
      read_mode <= 1'b0;
      busy <= 1'b0;
    end else if (clear_all) begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      ack_pend <= 1'b0;
      payload_only <= 1'b0;
      sel_ram <= 1'b0;
      have_sel <= 1'b0;
      read_mode <= 1'b0;
      busy <= 1'b0;
    end else begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      shift <= next_shift;
      ack_pend <= next_ack_pend;
      payload_only <= next_payload_only;
      sel_ram <= next_sel_ram;
      have_sel <= next_have_sel;
      read_mode <= next_read_mode;
      busy <= next_busy;
    end
  end

  // ----------------------------------------
  // Acknowledge driver
  // ----------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sda_out <= 1'b1;
      sda_oe <= 1'b0;
    end else if (clear_all || bus_event) begin
      // Never hold the line across a start or stop
      sda_out <= 1'b1;
      sda_oe <= 1'b0;
    end else if (ack_on) begin
      // Pull low across the whole ninth high period
      sda_oe <= 1'b1;
      sda_out <= 1'b0;
    end else if (ack_off) begin
      // Ack done; missing ack is master's concern when pin is open
      sda_oe <= 1'b0;
      sda_out <= 1'b1;
    end
  end

  // ----------------------------------------
  // Payload outputs
  // ----------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_valid <= 1'b0;
      cmd_byte <= 8'h00;
      ram_valid <= 1'b0;
      ram_byte <= 8'h00;
    end else if (clear_all) begin
      cmd_valid <= 1'b0;
      cmd_byte <= 8'h00;
      ram_valid <= 1'b0;
      ram_byte <= 8'h00;
    end else begin
      // Strobes last one cycle; bytes hold until the next of their kind
      cmd_valid <= payload_done && !sel_ram;
      ram_valid <= payload_done && sel_ram;
      if (payload_done && sel_ram) begin
        ram_byte <= full_byte;
      end
      if (payload_done && !sel_ram) begin
        cmd_byte <= full_byte;
      end
    end
  end

  // ----------------------------------------
  // Column pointer
  // ----------------------------------------
  // Wraps at its width; window limits are for the command decoder
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ram_col <= {COL_WIDTH{1'b0}};
    end else if (clear_all) begin
      ram_col <= {COL_WIDTH{1'b0}};
    end else if (payload_done && sel_ram) begin
      ram_col <= ram_col + col_step;
    end
  end

endmodule

`default_nettype wire

// >>> verif/i2cdw_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module i2cdw_asserts #(
  parameter COL_WIDTH = 7
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic chip_init_pin_n,
  input wire logic scl,
  input wire logic sda_in,
  input wire logic address_select_bit,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic read_mode,
  input wire logic busy,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_byte,
  input wire logic ram_valid,
  input wire logic [7:0] ram_byte,
  input wire logic [COL_WIDTH-1:0] ram_col
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_ack_drive_low: assert property (sda_oe |-> !sda_out) else $error("ack not low");
  chk_ack_full_pulse: assert property ($rose(sda_oe) |-> sda_oe [*6]) else $error("ack short");
  chk_ack_scl_low: assert property ($rose(sda_oe) |-> !scl) else $error("ack starts in high");
  chk_col_step_one: assert property ($changed(ram_col) && ram_col != 0 |-> ram_col == $past(ram_col) + 1'b1)
    else $error("column jump");
  chk_one_kind: assert property (!(cmd_valid && ram_valid)) else $error("both kinds");
  chk_pulse_once: assert property (cmd_valid || ram_valid |=> !(cmd_valid || ram_valid))
    else $error("valid too long");
  chk_idle_quiet: assert property (!busy |-> !cmd_valid && !ram_valid && !sda_oe) else $error("idle output");
  chk_init_clear: assert property (!chip_init_pin_n [*5] |-> !busy && !sda_oe && ram_col == 0)
    else $error("init no clear");
  chk_read_quiet: assert property (read_mode |-> !cmd_valid && !ram_valid) else $error("read wrote");
  cover property (ram_valid);
  cover property (cmd_valid);
  cover property ($rose(sda_oe));
  cover property ($rose(read_mode));
endmodule
bind i2cdw_top i2cdw_asserts #(.COL_WIDTH(COL_WIDTH)) i_i2cdw_asserts (.clk(clk), .rst_n(rst_n),
  .chip_init_pin_n(chip_init_pin_n), .scl(scl), .sda_in(sda_in), .address_select_bit(address_select_bit),
  .sda_out(sda_out), .sda_oe(sda_oe), .read_mode(read_mode), .busy(busy), .cmd_valid(cmd_valid),
  .cmd_byte(cmd_byte), .ram_valid(ram_valid), .ram_byte(ram_byte), .ram_col(ram_col));
`default_nettype wire

// >>> verif/i2cdw_master.sv
`timescale 1ns/1ps
`default_nettype none
module i2cdw_master (
  input wire logic clk,
  input wire logic sda_bus,
  output logic scl,
  output logic sda_drv
);
  // Bus idles high; scl stands still between frames
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task hp;
    repeat (4) @(posedge clk);
  endtask
  task start;
    sda_drv <= 1'b0;
    hp;
    scl <= 1'b0;
  endtask
  task stop;
    @(posedge clk);
    sda_drv <= 1'b0;
    hp;
    scl <= 1'b1;
    hp;
    sda_drv <= 1'b1;
    hp;
  endtask
  // Data moves one clock after scl falls, never beside it
  task clk_bit(input logic v, output logic s);
    @(posedge clk);
    sda_drv <= v;
    repeat (3) @(posedge clk);
    scl <= 1'b1;
    hp;
    s = sda_bus;
    scl <= 1'b0;
  endtask
  task send(input logic [7:0] b, input int n, output logic ack);
    logic s;
    ack = 1'b0;
    for (int i = 7; i > 7 - n; i--) clk_bit(b[i], s);
    if (n == 8) begin
      clk_bit(1'b1, s);
      ack = ~s;
    end
  endtask
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 1'b0, rst_n = 1'b0, init_n = 1'b1, sel = 1'b0, ack;
  logic sda_out, sda_oe, read_mode, busy, cmd_valid, ram_valid, scl, sda_m;
  logic [7:0] cmd_byte, ram_byte, last_cmd, last_ram, ncmd = 8'h00;
  logic [6:0] ram_col;
  wire logic sda_bus;
  int fails = 0, check_count = 0;
  assign sda_bus = sda_m & ~(sda_oe & ~sda_out);
  always #12.5 clk = ~clk;
  i2cdw_top i_i2cdw_top (.clk(clk), .rst_n(rst_n), .chip_init_pin_n(init_n), .scl(scl), .sda_in(sda_bus),
    .address_select_bit(sel), .sda_out(sda_out), .sda_oe(sda_oe), .read_mode(read_mode), .busy(busy),
    .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .ram_valid(ram_valid), .ram_byte(ram_byte), .ram_col(ram_col));
  i2cdw_master i_i2cdw_master (.clk(clk), .sda_bus(sda_bus), .scl(scl), .sda_drv(sda_m));
  always @(posedge clk) begin
    if (cmd_valid === 1'b1) begin
      last_cmd <= cmd_byte;
      ncmd <= ncmd + 8'h01;
    end
    if (ram_valid === 1'b1) last_ram <= ram_byte;
  end
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr(input logic [7:0] b, input logic ea);
    i_i2cdw_master.send(b, 8, ack);
    chk("ack", {7'h00, ea}, {7'h00, ack});
  endtask
  task stop_test;
    $display("fails=%0d check_count=%0d", fails, check_count);
    if (fails == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #300us;
    fails++;
    stop_test;
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    i_i2cdw_master.start;
    wr(8'h78, 1'b1);
    wr(8'h80, 1'b1);
    wr(8'hAE, 1'b1);
    chk("cmd", 8'hAE, last_cmd);
    wr(8'hC0, 1'b1);
    wr(8'h11, 1'b1);
    chk("ram", 8'h11, last_ram);
    chk("col", 8'h01, {1'b0, ram_col});
    wr(8'h40, 1'b1);
    wr(8'h22, 1'b1);
    wr(8'h33, 1'b1);
    chk("ram", 8'h33, last_ram);
    chk("col", 8'h03, {1'b0, ram_col});
    chk("ncmd", 8'h01, ncmd);
    i_i2cdw_master.stop;
    chk("busy", 8'h00, {7'h00, busy});
    sel <= 1'b1;
    i_i2cdw_master.start;
    wr(8'h78, 1'b0);
    wr(8'h00, 1'b0);
    wr(8'hAE, 1'b0);
    i_i2cdw_master.stop;
    chk("ncmd", 8'h01, ncmd);
    i_i2cdw_master.start;
    wr(8'h7A, 1'b1);
    wr(8'h00, 1'b1);
    wr(8'h40, 1'b1);
    wr(8'hC0, 1'b1);
    i_i2cdw_master.stop;
    chk("cmd", 8'hC0, last_cmd);
    chk("ncmd", 8'h03, ncmd);
    i_i2cdw_master.start;
    wr(8'h7B, 1'b1);
    chk("read", 8'h01, {7'h00, read_mode});
    i_i2cdw_master.stop;
    i_i2cdw_master.start;
    wr(8'h7A, 1'b1);
    chk("read", 8'h00, {7'h00, read_mode});
    i_i2cdw_master.send(8'hFF, 3, ack);
    init_n <= 1'b0;
    repeat (6) @(posedge clk);
    init_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk("busy", 8'h00, {7'h00, busy});
    chk("col", 8'h00, {1'b0, ram_col});
    i_i2cdw_master.stop;
    i_i2cdw_master.start;
    wr(8'h7A, 1'b1);
    wr(8'hC0, 1'b1);
    wr(8'h5A, 1'b1);
    chk("ram", 8'h5A, last_ram);
    chk("col", 8'h01, {1'b0, ram_col});
    i_i2cdw_master.stop;
    stop_test;
  end
endmodule
`default_nettype wire
